// ---- design/forwarding_table_access.sv ----
// Functional notes
// [R1] Two search result slots sit at bytes 68h-6Bh and 78h-7Bh.
// [R2] Result bit 16 shows the found entry's valid flag.
// [R3] Result bit 15 shows the found entry's static flag.
// [R4] Result bit 14 shows the found entry's aging flag.
// [R5] Result bits 13:11 show the found entry's traffic class.
// [R6] Reading a result slot clears it and lets the search continue.
// [R7] Multicast result bits 8:0 hold the port map, bit 8 the processor port.
// [R8] Unicast result bits 3:0 hold the station port, bits 8:4 read zero.
// [R9] Writing 1 to command bit 7 starts the selected VLAN table operation.
// [R10] The command start bit clears itself when the operation has finished.
// [R11] Operation field 00 writes, 01 reads, 10 clears table, 11 reserved.
// [R12] Index bits 11:0 select the VLAN entry for read or write.
// [R13] All these registers reset to zero; reserved read-only bits read zero.
// [R14] Search control bit 7 starts a search and clears when the search ends.
// [R15] Search control bit 0 sets on a found entry, clears after result read.
// [R16] VLAN entry contents pass through the data register at 83h-86h.
// [R17] Software leaves command, index and data alone while start reads 1.
// [R18] Clear-table zeroes every entry; read loads data before completion.
`timescale 1ns/1ps
module forwarding_table_access (
   input wire logic core_clk,
   input wire logic rst,
   input fwd_table_pkg::reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   output logic search_start,
   output logic search_take,
   input wire logic found_valid,
   input fwd_table_pkg::found_entry_type found_entry,
   input wire logic search_complete
);
   import fwd_table_pkg::*;

   // ***********************************************************************
   // State
   // ***********************************************************************
   typedef struct packed {
      logic search_run;
      logic search_hit_flag;
      logic start_pulse;
      logic [1:0] slot_full;
      logic [RESULT_W-1:0] slot0;
      logic [RESULT_W-1:0] slot1;
      logic vlan_start;
      logic [4:0] cmd_spare;
      logic [1:0] vlan_operation_select;
      logic [INDEX_W-1:0] vlan_entry_index;
      logic [ENTRY_W-1:0] vlan_data;
      vlan_state_type vstate;
      logic [INDEX_W-1:0] clear_ptr;
      logic [7:0] rdata;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   logic [ENTRY_W-1:0] table_mem [TABLE_DEPTH];
   logic [ENTRY_W-1:0] mem_q;
   logic mem_we;
   logic [INDEX_W-1:0] mem_addr;
   logic [ENTRY_W-1:0] mem_wdata;
   logic [RESULT_W-1:0] take_word;
   logic [31:0] res0_word;
   logic [31:0] res1_word;
   logic [31:0] data_word;
   logic [7:0] rd_byte;

   // ***********************************************************************
   // Result packing
   // ***********************************************************************
   // Unicast entries only carry a port number, so the upper map bits are
   // forced low rather than passing whatever the engine left there.
   always_comb begin
      take_word = '0;
      take_word[VALID_BIT] = found_entry.valid; // R2
      take_word[STATIC_BIT] = found_entry.static_f; // R3
      take_word[AGED_BIT] = found_entry.aged; // R4
      take_word[CLASS_LSB +: 3] = found_entry.found_entry_class; // R5
      if (found_entry.multicast) begin
         take_word[PORTS_W-1:0] = found_entry.ports; // R7
      end else begin
         take_word[STATION_W-1:0] = found_entry.ports[STATION_W-1:0]; // R8
      end
   end

   // Wide registers are zero padded so reserved bits read as zero.
   assign res0_word = {{(32 - RESULT_W){1'b0}}, s_r.slot0}; // R13
   assign res1_word = {{(32 - RESULT_W){1'b0}}, s_r.slot1};
   assign data_word = {{(32 - ENTRY_W){1'b0}}, s_r.vlan_data}; // R16

   // The engine may hand over an entry only while a slot is free.
   assign search_take = s_r.search_run && !(&s_r.slot_full); // R6
   assign search_start = s_r.start_pulse;
   assign reg_rdata = s_r.rdata;

   // ***********************************************************************
   // Read data multiplexer
   // ***********************************************************************
   always_comb begin
      rd_byte = RESET_BYTE;
      case (reg_req.addr)
         OFS_SEARCH_CTRL: begin
            rd_byte[START_BIT] = s_r.search_run;
            rd_byte[HIT_BIT] = s_r.search_hit_flag;
         end
         OFS_RESULT0: rd_byte = res0_word[7:0]; // R1
         OFS_RESULT0 + 8'h1: rd_byte = res0_word[15:8];
         OFS_RESULT0 + 8'h2: rd_byte = res0_word[23:16];
         OFS_RESULT0 + 8'h3: rd_byte = res0_word[31:24];
         OFS_RESULT1: rd_byte = res1_word[7:0];
         OFS_RESULT1 + 8'h1: rd_byte = res1_word[15:8];
         OFS_RESULT1 + 8'h2: rd_byte = res1_word[23:16];
         OFS_RESULT1 + 8'h3: rd_byte = res1_word[31:24];
         OFS_VLAN_CMD: rd_byte = {s_r.vlan_start, s_r.cmd_spare, s_r.vlan_operation_select};
         OFS_VLAN_INDEX: rd_byte = s_r.vlan_entry_index[7:0];
         OFS_VLAN_INDEX + 8'h1: rd_byte = {4'h0, s_r.vlan_entry_index[11:8]};
         OFS_VLAN_DATA: rd_byte = data_word[7:0];
         OFS_VLAN_DATA + 8'h1: rd_byte = data_word[15:8];
         OFS_VLAN_DATA + 8'h2: rd_byte = data_word[23:16];
         OFS_VLAN_DATA + 8'h3: rd_byte = data_word[31:24];
         default: rd_byte = RESET_BYTE;
      endcase
   end

   // ***********************************************************************
   // Next state
   // ***********************************************************************
   always_comb begin
      logic busy;
      logic rd0_clr;
      logic rd1_clr;
      busy = s_r.vlan_start;
      rd0_clr = reg_req.rd && (reg_req.addr == (OFS_RESULT0 + {6'h0, RESULT_CLEAR_BYTE}));
      rd1_clr = reg_req.rd && (reg_req.addr == (OFS_RESULT1 + {6'h0, RESULT_CLEAR_BYTE}));
      s_nxt = s_r;
      s_nxt.start_pulse = 1'b0;
      mem_we = 1'b0;
      mem_addr = s_r.vlan_entry_index;
      mem_wdata = s_r.vlan_data;
      if (reg_req.rd) begin
         s_nxt.rdata = rd_byte;
      end

      // Reading the top byte of a slot empties it; the hit flag drops once no
      // result is left, and a new entry in the same cycle wins over both.
      if (rd0_clr) begin
         s_nxt.slot0 = '0; // R6
         s_nxt.slot_full[0] = 1'b0;
      end
      if (rd1_clr) begin
         s_nxt.slot1 = '0; // R6
         s_nxt.slot_full[1] = 1'b0;
      end
      if ((rd0_clr || rd1_clr) && !(|s_nxt.slot_full)) begin
         s_nxt.search_hit_flag = 1'b0; // R15
      end
      if (found_valid && search_take) begin
         if (!s_r.slot_full[0]) begin
            s_nxt.slot0 = take_word;
            s_nxt.slot_full[0] = 1'b1;
         end else begin
            s_nxt.slot1 = take_word;
            s_nxt.slot_full[1] = 1'b1;
         end
         s_nxt.search_hit_flag = 1'b1; // R15
      end

      // Search control: a start while a search is running is ignored.
      if (search_complete) begin
         s_nxt.search_run = 1'b0; // R14
      end
      if (reg_req.wr && reg_req.addr == OFS_SEARCH_CTRL && reg_req.wdata[START_BIT]
          && !s_r.search_run) begin
         s_nxt.search_run = 1'b1; // R14
         s_nxt.start_pulse = 1'b1;
      end

      // Command, index and data are frozen while an operation runs, which
      // keeps the indexed read stable against careless software.
      if (reg_req.wr && !busy) begin
         case (reg_req.addr)
            OFS_VLAN_CMD: begin
               s_nxt.vlan_start = reg_req.wdata[START_BIT]; // R9
               s_nxt.cmd_spare = reg_req.wdata[6:2];
               s_nxt.vlan_operation_select = reg_req.wdata[1:0]; // R11
            end
            OFS_VLAN_INDEX: s_nxt.vlan_entry_index[7:0] = reg_req.wdata; // R12
            OFS_VLAN_INDEX + 8'h1: s_nxt.vlan_entry_index[11:8] = reg_req.wdata[3:0];
            OFS_VLAN_DATA: s_nxt.vlan_data[7:0] = reg_req.wdata; // R16
            OFS_VLAN_DATA + 8'h1: s_nxt.vlan_data[15:8] = reg_req.wdata;
            OFS_VLAN_DATA + 8'h2: s_nxt.vlan_data[21:16] = reg_req.wdata[5:0];
            default: begin
            end
         endcase
      end

      // VLAN table sequencer.
      case (s_r.vstate)
         VLAN_IDLE: begin
            if (s_r.vlan_start) begin
               case (s_r.vlan_operation_select)
                  OP_WRITE: begin
                     mem_we = 1'b1; // R12
                     s_nxt.vlan_start = 1'b0; // R10
                  end
                  OP_READ: s_nxt.vstate = VLAN_READ;
                  OP_CLEAR: begin
                     s_nxt.vstate = VLAN_CLEAR;
                     s_nxt.clear_ptr = '0;
                  end
                  default: s_nxt.vlan_start = 1'b0; // R11
               endcase
            end
         end
         VLAN_READ: begin
            s_nxt.vlan_data = mem_q; // R18
            s_nxt.vlan_start = 1'b0; // R10
            s_nxt.vstate = VLAN_IDLE;
         end
         VLAN_CLEAR: begin
            // One entry per cycle: the whole table takes 4096 cycles.
            mem_we = 1'b1;
            mem_addr = s_r.clear_ptr; // R18
            mem_wdata = '0;
            s_nxt.clear_ptr = s_r.clear_ptr + 12'h1;
            if (s_r.clear_ptr == LAST_INDEX) begin
               s_nxt.vlan_start = 1'b0; // R10
               s_nxt.vstate = VLAN_IDLE;
            end
         end
         default: s_nxt.vstate = VLAN_IDLE;
      endcase
   end

   // ***********************************************************************
   // Registers
   // ***********************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0; // R13
      end else begin
         s_r <= s_nxt;
      end
   end

   // The table is plain storage without reset; only clear-table zeroes it.
   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         table_mem[mem_addr] <= mem_wdata;
      end
      mem_q <= table_mem[s_r.vlan_entry_index];
   end

   // ***********************************************************************
   // Assertions
   // ***********************************************************************
   sequence s_cmd_begins(logic [1:0] op);
      $rose(s_r.vlan_start) && s_r.vlan_operation_select == op;
   endsequence

   property p_write_done;
      @(posedge core_clk) disable iff (rst)
      s_cmd_begins(OP_WRITE) |=> !s_r.vlan_start;
   endproperty
   a_write_done: assert property (p_write_done) else $error("write not done"); // R10

   property p_read_done;
      @(posedge core_clk) disable iff (rst)
      s_cmd_begins(OP_READ) |=> s_r.vlan_start
         ##1 (!s_r.vlan_start && s_r.vlan_data == $past(mem_q));
   endproperty
   a_read_done: assert property (p_read_done) else $error("read wrong"); // R18

   property p_clear_busy;
      @(posedge core_clk) disable iff (rst)
      s_cmd_begins(OP_CLEAR) |-> s_r.vlan_start [*8];
   endproperty
   a_clear_busy: assert property (p_clear_busy) else $error("clear ended early"); // R11

   property p_hit_on_take;
      @(posedge core_clk) disable iff (rst)
      found_valid && search_take |=> s_r.search_hit_flag && (|s_r.slot_full);
   endproperty
   a_hit_on_take: assert property (p_hit_on_take) else $error("hit not set"); // R15

   property p_slot_read_clears;
      @(posedge core_clk) disable iff (rst)
      reg_req.rd && reg_req.addr == OFS_RESULT0 + 8'h3 && !(found_valid && search_take)
      |=> s_r.slot0 == '0 && !s_r.slot_full[0];
   endproperty
   a_slot_read_clears: assert property (p_slot_read_clears) else $error("slot kept"); // R6

   property p_reserved_zero;
      @(posedge core_clk) disable iff (rst)
      reg_req.rd && reg_req.addr == OFS_RESULT1 + 8'h3 |=> reg_rdata == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set"); // R13

   property p_unicast_mask;
      @(posedge core_clk) disable iff (rst)
      found_valid && search_take && !found_entry.multicast && !s_r.slot_full[0]
      |=> s_r.slot0[PORTS_W-1:STATION_W] == '0 && s_r.slot0[VALID_BIT] == $past(found_entry.valid);
   endproperty
   a_unicast_mask: assert property (p_unicast_mask) else $error("unicast bits"); // R8

   property p_search_end;
      @(posedge core_clk) disable iff (rst)
      search_complete && !reg_req.wr |=> !s_r.search_run && !search_take;
   endproperty
   a_search_end: assert property (p_search_end) else $error("search runs on"); // R14

endmodule // forwarding_table_access

// ---- design/fwd_table_pkg.sv ----
package fwd_table_pkg;

   // ***********************************************************************
   // Register offsets inside the switch page, byte addressed
   // ***********************************************************************
   localparam logic [7:0] OFS_SEARCH_CTRL = 8'h50;
   localparam logic [7:0] OFS_RESULT0 = 8'h68;
   localparam logic [7:0] OFS_RESULT1 = 8'h78;
   localparam logic [7:0] OFS_VLAN_CMD = 8'h80;
   localparam logic [7:0] OFS_VLAN_INDEX = 8'h81;
   localparam logic [7:0] OFS_VLAN_DATA = 8'h83;
   localparam logic [1:0] RESULT_CLEAR_BYTE = 2'h3;

   // ***********************************************************************
   // Field positions
   // ***********************************************************************
   localparam int START_BIT = 7;
   localparam int HIT_BIT = 0;
   localparam int VALID_BIT = 16;
   localparam int STATIC_BIT = 15;
   localparam int AGED_BIT = 14;
   localparam int CLASS_LSB = 11;
   localparam int PORTS_W = 9;
   localparam int STATION_W = 4;
   localparam int RESULT_W = 17;
   localparam int INDEX_W = 12;
   localparam int ENTRY_W = 22;
   localparam int TABLE_DEPTH = 4096;
   localparam logic [INDEX_W-1:0] LAST_INDEX = 12'hfff;

   // ***********************************************************************
   // Operation codes and reset values
   // ***********************************************************************
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_CLEAR = 2'h2;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   typedef enum logic [1:0] {
      VLAN_IDLE,
      VLAN_READ,
      VLAN_CLEAR
   } vlan_state_type;

   // Entry reported by the address lookup search engine.
   typedef struct packed {
      logic multicast;
      logic valid;
      logic static_f;
      logic aged;
      logic [2:0] found_entry_class;
      logic [PORTS_W-1:0] ports;
   } found_entry_type;

   // One byte access on the register port.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

endpackage

// ---- dv/forwarding_table_access_tb_top.sv ----
`timescale 1ns/1ps
module forwarding_table_access_tb_top;
   import fwd_table_pkg::*;

   // ************************************************************
   // Stimulus signals, clock and the block under test
   // ************************************************************
   logic core_clk;
   logic rst;
   reg_req_type reg_req;
   logic [7:0] reg_rdata;
   logic search_start;
   logic search_take;
   logic found_valid;
   found_entry_type found_entry;
   logic search_complete;
   int error_cnt;
   int checks;
   logic [7:0] rd_val;
   logic [24:0] rows [0:23];
   found_entry_type e0;
   found_entry_type e1;

   forwarding_table_access uut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .search_start(search_start),
      .search_take(search_take),
      .found_valid(found_valid),
      .found_entry(found_entry),
      .search_complete(search_complete)
   );

   // The clock toggles every 2.5 ns, a period of 5 ns.
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ************************************************************
   // Compare, bus and closing tasks
   // ************************************************************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Each access takes two cycles so a strobe never rises in the step it fell.
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(negedge core_clk);
      reg_req.wr = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic rd_byte(input logic [7:0] a);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge core_clk);
      reg_req.rd = 1'b0;
      rd_val = reg_rdata;
      @(negedge core_clk);
   endtask

   task automatic rd_word(input logic [7:0] a, input logic [31:0] exp);
      for (int i = 0; i < 4; i++) begin
         rd_byte(a + 8'(i));
         chk8(rd_val, exp[8*i+:8]);
      end
   endtask

   // Unicast entries carry only a port number, so the upper map bits read zero.
   function automatic logic [31:0] slot_word(input found_entry_type e);
      logic [8:0] p;
      p = e.multicast ? e.ports : {5'h00, e.ports[3:0]};
      return {15'h0000, e.valid, e.static_f, e.aged, e.found_entry_class, 2'h0, p};
   endfunction

   task automatic push(input found_entry_type e);
      int n;
      n = 0;
      while (search_take !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      // A slot that never frees up is a mismatch, not a silent skip.
      if (search_take !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, search_take, 1'b1);
      end
      found_entry = e;
      found_valid = 1'b1;
      @(negedge core_clk);
      found_valid = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic vlan_wait(input logic [1:0] op);
      int n;
      n = 0;
      rd_byte(OFS_VLAN_CMD);
      while (rd_val[START_BIT] !== 1'b0 && n < 3000) begin
         rd_byte(OFS_VLAN_CMD);
         n++;
      end
      chk8(rd_val, {6'h00, op});
      chk1((op == OP_CLEAR) == (n >= 2000), 1'b1);
   endtask

   task automatic vlan_cmd(input logic [1:0] op);
      wr_byte(OFS_VLAN_CMD, {1'b1, 5'h00, op});
      vlan_wait(op);
   endtask

   task automatic print_verdict();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // A hang is cut short well after three full table clears would end.
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      error_cnt = 0;
      checks = 0;
      rst = 1'b1;
      reg_req = '0;
      found_valid = 1'b0;
      found_entry = '0;
      search_complete = 1'b0;
      rows = '{{1'b0, 8'h68, 8'h00, 8'h00}, {1'b0, 8'h69, 8'h00, 8'h00},
               {1'b0, 8'h6a, 8'h00, 8'h00}, {1'b0, 8'h6b, 8'h00, 8'h00},
               {1'b0, 8'h78, 8'h00, 8'h00}, {1'b0, 8'h7b, 8'h00, 8'h00},
               {1'b0, 8'h50, 8'h00, 8'h00}, {1'b0, 8'h80, 8'h00, 8'h00},
               {1'b0, 8'h81, 8'h00, 8'h00}, {1'b0, 8'h82, 8'h00, 8'h00},
               {1'b0, 8'h83, 8'h00, 8'h00}, {1'b0, 8'h86, 8'h00, 8'h00},
               {1'b1, 8'h81, 8'hff, 8'hff}, {1'b1, 8'h82, 8'hff, 8'h0f},
               {1'b1, 8'h80, 8'h7c, 8'h7c}, {1'b1, 8'h85, 8'hff, 8'h3f},
               {1'b1, 8'h86, 8'hff, 8'h00}, {1'b1, 8'h90, 8'hff, 8'h00},
               {1'b1, 8'h6a, 8'hff, 8'h00}, {1'b1, 8'h80, 8'h00, 8'h00},
               {1'b1, 8'h81, 8'h00, 8'h00}, {1'b1, 8'h82, 8'h00, 8'h00},
               {1'b1, 8'h85, 8'h00, 8'h00}, {1'b1, 8'h83, 8'h5a, 8'h5a}};
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      for (int i = 0; i < 24; i++) begin
         if (rows[i][24]) begin
            wr_byte(rows[i][23:16], rows[i][15:8]);
         end
         rd_byte(rows[i][23:16]);
         chk8(rd_val, rows[i][7:0]);
      end
      $display("test register table done");
      // A clear ignores the index, and writes that land while it runs are dropped.
      wr_byte(OFS_VLAN_INDEX, 8'h21);
      wr_byte(OFS_VLAN_CMD, 8'h82);
      wr_byte(OFS_VLAN_INDEX, 8'h55);
      vlan_wait(OP_CLEAR);
      rd_byte(OFS_VLAN_INDEX);
      chk8(rd_val, 8'h21);
      wr_byte(8'h83, 8'h56);
      wr_byte(8'h84, 8'h34);
      wr_byte(8'h85, 8'h12);
      wr_byte(OFS_VLAN_INDEX, 8'ha5);
      vlan_cmd(OP_WRITE);
      wr_byte(8'h83, 8'h00);
      wr_byte(8'h84, 8'h00);
      wr_byte(8'h85, 8'h00);
      wr_byte(8'h82, 8'h05);
      vlan_cmd(OP_READ);
      rd_word(OFS_VLAN_DATA, 32'h0);
      wr_byte(8'h82, 8'h00);
      vlan_cmd(OP_READ);
      rd_word(OFS_VLAN_DATA, 32'h00123456);
      vlan_cmd(2'h3);
      vlan_cmd(OP_CLEAR);
      vlan_cmd(OP_READ);
      rd_word(OFS_VLAN_DATA, 32'h0);
      $display("test vlan commands done");
      // Search start pulses once, then two finds fill both slots.
      reg_req.wr = 1'b1;
      reg_req.addr = OFS_SEARCH_CTRL;
      reg_req.wdata = 8'h80;
      @(negedge core_clk);
      reg_req.wr = 1'b0;
      chk1(search_start, 1'b1);
      chk1(search_take, 1'b1);
      @(negedge core_clk);
      chk1(search_start, 1'b0);
      e0 = '{multicast: 1'b1, valid: 1'b1, static_f: 1'b1, aged: 1'b0,
             found_entry_class: 3'h5, ports: 9'h1a5};
      e1 = '{multicast: 1'b0, valid: 1'b1, static_f: 1'b0, aged: 1'b1,
             found_entry_class: 3'h2, ports: 9'h1f3};
      push(e0);
      push(e1);
      chk1(search_take, 1'b0);
      rd_byte(OFS_SEARCH_CTRL);
      chk8(rd_val, 8'h81);
      rd_word(OFS_RESULT0, slot_word(e0));
      chk1(search_take, 1'b1);
      rd_byte(OFS_RESULT0);
      chk8(rd_val, 8'h00);
      rd_byte(OFS_SEARCH_CTRL);
      chk8(rd_val, 8'h81);
      rd_word(OFS_RESULT1, slot_word(e1));
      rd_byte(OFS_SEARCH_CTRL);
      chk8(rd_val, 8'h80);
      // With both slots empty again a unicast find lands in the first slot.
      push(e1);
      rd_word(OFS_RESULT0, slot_word(e1));
      search_complete = 1'b1;
      @(negedge core_clk);
      search_complete = 1'b0;
      @(negedge core_clk);
      chk1(search_take, 1'b0);
      rd_byte(OFS_SEARCH_CTRL);
      chk8(rd_val, 8'h00);
      $display("test search results done");
      // A second reset in mid-run, with a search running and the index set.
      wr_byte(OFS_VLAN_INDEX, 8'h3c);
      wr_byte(OFS_SEARCH_CTRL, 8'h80);
      rst = 1'b1;
      @(negedge core_clk);
      chk8(reg_rdata, 8'h00);
      chk1(search_take, 1'b0);
      chk1(search_start, 1'b0);
      rst = 1'b0;
      @(negedge core_clk);
      rd_byte(OFS_VLAN_INDEX);
      chk8(rd_val, 8'h00);
      rd_byte(OFS_SEARCH_CTRL);
      chk8(rd_val, 8'h00);
      $display("test mid-run reset done");
      print_verdict();
   end

endmodule // forwarding_table_access_tb_top
